// *** src/pwmto_map.vh ***
// Constants for the standard pulse-width output block.
// Assumes inclusion by bare name from the block's design files.
`ifndef PWMTO_MAP_VH
`define PWMTO_MAP_VH

`define PWMTO_PERIOD_W      8
`define PWMTO_DUTY_W        10
`define PWMTO_FRAC_W        2
`define PWMTO_PRESC_W       2
`define PWMTO_PERIOD_RST    8'hff
`define PWMTO_DUTY_RST      10'h000
`define PWMTO_PRESC_1       2'h0
`define PWMTO_PRESC_4       2'h1
`define PWMTO_PRESC_16      2'h2
`define PWMTO_PRESC_64      2'h3

`endif

// *** src/pwmto_prescaler.v ***
// Timer input prescaler: turns the system clock into a tick enable.
// Assumes one clock; advance only while the timer is running and awake.
`timescale 1ns/1ns
`include "pwmto_map.vh"

module pwmto_prescaler (
    input  wire                      clk,
    input  wire                      rst_b,
    input  wire                      run,
    input  wire [`PWMTO_PRESC_W-1:0] sel,
    output reg                       tick
);

    reg [5:0] div_q;
    reg [5:0] div_d;
    reg [5:0] lim;

    always @* begin
        case (sel)
            `PWMTO_PRESC_1:  lim = 6'h00;
            `PWMTO_PRESC_4:  lim = 6'h03;
            `PWMTO_PRESC_16: lim = 6'h0f;
            default:         lim = 6'h3f;
        endcase
        tick  = run && (div_q >= lim);
        div_d = tick ? 6'h00 : div_q + 6'h01;
    end

    // Holding the count while stopped keeps sleep from shifting phase
    always @(posedge clk) begin
        if (!rst_b) begin
            div_q <= 6'h00;
        end else if (run) begin
            div_q <= div_d;
        end
    end

endmodule // pwmto_prescaler

// *** src/pwmto_top.v ***
// Standard pulse-width output: period timer, period match, duty compare.
// Assumes configuration inputs come from logic on SYS_CLK; SLEEP is a pin.
//
// Notes on behaviour
// - Pulse width resolution up to ten bits
// - Output high for on time, else low
// - Zero duty low always; full duty high
// - Period, duty, resolution set by control inputs
// - Sleep freezes timer, fraction and duty state; pin direction still follows
// - Pin keeps its level during sleep while CCP_ENABLE is high
// - Timer resumes from held value on wake
// - Output rate is system clock divided by prescaler, four fractional steps per count and period limit plus one
// - Reset makes pin input, registers default
// - High at period start, low on match
// - Timer clears on period match, restarts
`timescale 1ns/1ns
`include "pwmto_map.vh"

module pwmto_top #(
    parameter PERIOD_W = `PWMTO_PERIOD_W,
    parameter DUTY_W   = `PWMTO_DUTY_W
) (
    input  wire                      SYS_CLK,
    input  wire                      RST_B,
    input  wire                      SLEEP,
    input  wire                      TIMER_ON,
    input  wire [`PWMTO_PRESC_W-1:0] TIMER_PRESCALE,
    input  wire                      CCP_ENABLE,
    input  wire [PERIOD_W-1:0]       PERIOD_LIMIT_REGISTER,
    input  wire [DUTY_W-1:0]         DUTY_VALUE_REGISTER,
    input  wire                      PIN_DIRECTION_BIT,
    output reg                       MODULATED_OUTPUT_PIN,
    output reg                       MODULATED_OUTPUT_PIN_OE,
    output reg  [PERIOD_W-1:0]       PERIOD_TIMER_COUNT,
    output reg                       PERIOD_START
);

    localparam FRAC_W = `PWMTO_FRAC_W;

    ////////////////////////////////////////////////////////////////////////
    // Sleep pin synchroniser

    reg sleep_s1_q;
    reg sleep_s2_q;

    always @(posedge SYS_CLK) begin
        if (!RST_B) begin
            sleep_s1_q <= 1'b0;
            sleep_s2_q <= 1'b0;
        end else begin
            sleep_s1_q <= SLEEP;
            sleep_s2_q <= sleep_s1_q;
        end
    end

    wire awake = !sleep_s2_q;

    ////////////////////////////////////////////////////////////////////////
    // Time base

    wire tick;

    pwmto_prescaler u_presc (
        .clk   (SYS_CLK),
        .rst_b (RST_B),
        .run   (TIMER_ON && awake),
        .sel   (TIMER_PRESCALE),
        .tick  (tick)
    );

    // Two fractional bits step on each prescaled tick below the count
    reg  [FRAC_W-1:0] frac_q;
    reg  [FRAC_W-1:0] frac_d;
    reg  [PERIOD_W-1:0] tmr_d;
    reg  [DUTY_W-1:0] duty_q;
    reg  [DUTY_W-1:0] duty_d;
    reg               out_d;
    reg               start_d;
    wire              step = TIMER_ON && awake;
    wire [DUTY_W-1:0] fine = {PERIOD_TIMER_COUNT, frac_q};
    wire              match = (PERIOD_TIMER_COUNT == PERIOD_LIMIT_REGISTER);

    always @* begin
        frac_d  = frac_q;
        tmr_d   = PERIOD_TIMER_COUNT;
        duty_d  = duty_q;
        out_d   = MODULATED_OUTPUT_PIN;
        start_d = 1'b0;
        if (step) begin
            // Stepping on tick keeps on time scaled with the period
            if (tick) begin
                frac_d = frac_q + {{(FRAC_W-1){1'b0}}, 1'b1};
            end
            if (frac_q == {FRAC_W{1'b1}} && tick) begin
                if (match) begin
                    tmr_d   = {PERIOD_W{1'b0}};
                    duty_d  = DUTY_VALUE_REGISTER;
                    start_d = 1'b1;
                    // High at start unless duty is zero
                    out_d   = (DUTY_VALUE_REGISTER != {DUTY_W{1'b0}});
                end else begin
                    tmr_d = PERIOD_TIMER_COUNT + {{(PERIOD_W-1){1'b0}}, 1'b1};
                end
            end
            // Duty above period never matches so output stays high
            if (tick && !start_d && (fine + {{(DUTY_W-1){1'b0}}, 1'b1}) == duty_q) begin
                out_d = 1'b0;
            end
        end
        if (!CCP_ENABLE) begin
            out_d = 1'b0;
        end
    end

    always @(posedge SYS_CLK) begin
        if (!RST_B) begin
            frac_q                  <= {FRAC_W{1'b0}};
            PERIOD_TIMER_COUNT      <= {PERIOD_W{1'b0}};
            duty_q                  <= `PWMTO_DUTY_RST;
            MODULATED_OUTPUT_PIN    <= 1'b0;
            PERIOD_START            <= 1'b0;
        end else begin
            // Timer and duty hold when asleep; pin holds last level unless CCP_ENABLE is low
            frac_q               <= frac_d;
            PERIOD_TIMER_COUNT   <= tmr_d;
            duty_q               <= duty_d;
            MODULATED_OUTPUT_PIN <= out_d;
            PERIOD_START         <= start_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin direction

    always @(posedge SYS_CLK) begin
        if (!RST_B) begin
            MODULATED_OUTPUT_PIN_OE <= 1'b0;
        end else begin
            MODULATED_OUTPUT_PIN_OE <= !PIN_DIRECTION_BIT;
        end
    end

endmodule // pwmto_top

// *** testbench/pwmto_props.sv ***
// Port checks for the pulse-width output block.
// Bound to pwmto_top; period limit held steady.
`timescale 1ns/1ns
module pwmto_props #(
    parameter PERIOD_W = 8
) (
    input wire                SYS_CLK,
    input wire                RST_B,
    input wire                SLEEP,
    input wire                TIMER_ON,
    input wire                CCP_ENABLE,
    input wire                PIN_DIRECTION_BIT,
    input wire [PERIOD_W-1:0] PERIOD_LIMIT_REGISTER,
    input wire                MODULATED_OUTPUT_PIN,
    input wire                MODULATED_OUTPUT_PIN_OE,
    input wire [PERIOD_W-1:0] PERIOD_TIMER_COUNT,
    input wire                PERIOD_START
);
default clocking @(posedge SYS_CLK); endclocking
default disable iff (!RST_B);
// Four samples: sleep passes two sync flops
sequence s_asleep; SLEEP [*4]; endsequence
start_pulse_a: assert property (PERIOD_START |=> !PERIOD_START) else $error("long start");
start_zero_a: assert property (PERIOD_START |-> PERIOD_TIMER_COUNT == 0) else $error("start");
count_limit_a: assert property (PERIOD_TIMER_COUNT <= PERIOD_LIMIT_REGISTER) else $error("lim");
count_step_a: assert property ($changed(PERIOD_TIMER_COUNT) |-> PERIOD_START ||
    PERIOD_TIMER_COUNT == $past(PERIOD_TIMER_COUNT) + 1'b1) else $error("step");
sleep_hold_a: assert property (s_asleep |=> $stable(PERIOD_TIMER_COUNT) &&
    $stable(MODULATED_OUTPUT_PIN)) else $error("sleep");
timer_off_a: assert property (!TIMER_ON |=> $stable(PERIOD_TIMER_COUNT)) else $error("off");
oe_follow_a: assert property ($past(RST_B) |->
    MODULATED_OUTPUT_PIN_OE == !$past(PIN_DIRECTION_BIT)) else $error("oe");
ccp_off_a: assert property (!CCP_ENABLE |=> !MODULATED_OUTPUT_PIN) else $error("ccp");
reset_vals_a: assert property (disable iff (1'b0) !RST_B |=> !MODULATED_OUTPUT_PIN_OE &&
    !MODULATED_OUTPUT_PIN && PERIOD_TIMER_COUNT == 0) else $error("reset");
endmodule // pwmto_props

// *** testbench/pwmto_load.sv ***
// Power load model: counts cycles it is driven high.
// Assumes sampling on the system clock.
`timescale 1ns/1ns
module pwmto_load (
    input  wire clk,
    input  wire pin,
    input  wire oe,
    output int  on_n
);
initial on_n = 0;
// Undriven pin delivers no power
always @(posedge clk) if (oe && pin === 1'b1) on_n <= on_n + 1;
endmodule // pwmto_load

// *** testbench/tb_pwm_timer_output.sv ***
// Bench for the pulse-width output block with a load.
// Assumes period limit 1: eight cycles a period at /1.
`timescale 1ns/1ns
module tb_pwm_timer_output;
reg        sys_clk = 0, rst_b = 0, sleep = 0, tmr_on = 1, ccp_en = 1, dir = 1;
reg  [1:0] presc = 2'h0;
reg  [9:0] duty = 10'h000, c;
wire       pin, oe, start;
wire [7:0] cnt;
int        on_n, a, n_fail = 0, checks_done = 0;
pwmto_top i_dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .SLEEP(sleep), .TIMER_ON(tmr_on),
    .TIMER_PRESCALE(presc), .CCP_ENABLE(ccp_en), .PERIOD_LIMIT_REGISTER(8'h01),
    .DUTY_VALUE_REGISTER(duty), .PIN_DIRECTION_BIT(dir), .MODULATED_OUTPUT_PIN(pin),
    .MODULATED_OUTPUT_PIN_OE(oe), .PERIOD_TIMER_COUNT(cnt), .PERIOD_START(start));
pwmto_load i_load (.clk(sys_clk), .pin(pin), .oe(oe), .on_n(on_n));
initial forever #5 sys_clk = ~sys_clk;
////////////////////////////////////////
task chk(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
        n_fail++;
        $display("ERROR %0t got %0h want %0h", $time, got, exp);
    end
endtask
task cyc(input int n);
    repeat (n) @(negedge sys_clk);
endtask
task wait_start;
    for (int i = 0; i < 40 && start !== 1'b1; i++) cyc(1);
    if (start !== 1'b1) begin n_fail++; finish_test; end
endtask
task t_pins;
    dir = 0;
    cyc(2);
    chk(oe, 1);
    tmr_on = 0;
    c = cnt;
    cyc(6);
    chk(cnt, c);
    tmr_on = 1;
    ccp_en = 0;
    cyc(2);
    chk(pin, 0);
    ccp_en = 1;
    $display("t_pins done");
endtask
task t_duty;
    int dl[5] = '{0, 2, 5, 8, 12};
    // Two starts: new duty waits for a period edge
    foreach (dl[i]) begin
        duty = dl[i];
        cyc(1); wait_start; cyc(1); wait_start;
        a = on_n;
        cyc(24);
        chk(on_n - a, (dl[i] > 8 ? 8 : dl[i]) * 3);
    end
    $display("t_duty done");
endtask
task t_sleep;
    duty = 5;
    cyc(1); wait_start; cyc(1); wait_start; cyc(1);
    sleep = 1;
    cyc(4);
    c = {cnt, pin};
    cyc(20);
    chk({cnt, pin}, c);
    sleep = 0;
    cyc(2); wait_start;
    a = on_n;
    cyc(8);
    chk(on_n - a, 5);
    $display("t_sleep done");
endtask
task t_presc;
    presc = 2'h1;
    duty = 5;
    cyc(1); wait_start; cyc(1); wait_start;
    a = on_n;
    cyc(32);
    chk(on_n - a, 20);
    presc = 2'h0;
    $display("t_presc done");
endtask
task finish_test;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
endtask
initial begin
    cyc(8);
    rst_b = 1;
    cyc(1);
    chk({cnt, oe, pin}, 10'h000);
    t_pins;
    t_duty;
    t_sleep;
    t_presc;
    finish_test;
end
endmodule // tb_pwm_timer_output
bind pwmto_top pwmto_props #(.PERIOD_W(PERIOD_W)) i_props (.*);
